// ---- common/rail_vid_pkg.sv ----
// constants for the rail address and voltage code encoder
// assumes a single 50 MHz clock and a request/accept handshake from the power manager
// Overview of operation
// - every packet carries a four-bit rail address selecting one regulator segment.
// - address 0 core rail, 1 system agent rail, 2 memory supply rail; 3-F unused.
// - code zero turns the rail off; codes 01 to 32 hex never sent.
// - code 33 hex is 0.5 V, plus 5 mV per step, up to FF at 1.52 V.
// - memory supply rail only gets the off code or one fixed code, for 1.35 V or 1.5 V.
package rail_vid_pkg;
    localparam int ADDR_W = 4;
    localparam int CODE_W = 8;
    localparam int MV_W   = 11;

    localparam logic [ADDR_W-1:0] ADDR_CORE   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_SYSAG  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MEMSUP = 4'h2;

    localparam logic [CODE_W-1:0] CODE_OFF = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MIN = 8'h33;
    localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;
    // fixed memory rail codes for 1.35 V and 1.5 V
    localparam logic [CODE_W-1:0] CODE_MEM_LOW  = 8'hDD;
    localparam logic [CODE_W-1:0] CODE_MEM_HIGH = 8'hFB;

    // millivolts; one code step is 5 mV
    localparam logic [MV_W-1:0] MV_MIN  = 11'd500;
    localparam logic [MV_W-1:0] MV_MAX  = 11'd1520;
    localparam logic [MV_W-1:0] MV_STEP = 11'd5;
    localparam logic [MV_W-1:0] MV_MEM_LOW  = 11'd1350;
    localparam logic [MV_W-1:0] MV_MEM_HIGH = 11'd1500;

    typedef enum logic [1:0] {
        REJ_NONE,
        REJ_ADDR,
        REJ_RANGE,
        REJ_MEMFIX
    } reject_e;
endpackage

// ---- hw/mv_to_code.sv ----
// millivolt to voltage code converter, purely combinational
// assumes the caller checks range flags before using the code
`timescale 1ns/1ps
module mv_to_code
    import rail_vid_pkg::*;
(
    // request
    input  wire logic [MV_W-1:0]   milliVolts,
    // result
    output logic      [CODE_W-1:0] voltageIdentCode,
    output logic                   inRange
);
    logic [MV_W-1:0] offsetMv;
    logic [MV_W-1:0] steps;

    always_comb begin
        offsetMv = milliVolts - MV_MIN;
        steps    = offsetMv / MV_STEP;
        // off request and exact 5 mV grid only; nothing between off and the floor
        inRange  = (milliVolts == '0) ||
                   ((milliVolts >= MV_MIN) && (milliVolts <= MV_MAX) && ((offsetMv % MV_STEP) == '0));
        if (milliVolts == '0) begin
            voltageIdentCode = CODE_OFF;
        end else begin
            voltageIdentCode = CODE_MIN + steps[CODE_W-1:0];
        end
    end
endmodule

// ---- hw/regulator_rail_vid_encoder.sv ----
// encoder turning a rail select and target voltage into an address and code packet
// holds sendValid and the packet until the downstream serialiser raises sendReady
`timescale 1ns/1ps
module regulator_rail_vid_encoder
    import rail_vid_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // request from the power manager
    input  wire logic              reqValid,
    input  wire logic [ADDR_W-1:0] reqRail,
    input  wire logic [MV_W-1:0]   reqMilliVolts,
    output logic                   reqReady,
    // memory supply fixed setpoint: 0 selects 1.35 V, 1 selects 1.5 V
    input  wire logic              memHighSel,
    // packet to the serial bus engine
    output logic                   sendValid,
    output logic [ADDR_W-1:0]      sendAddr,
    output logic [CODE_W-1:0]      sendCode,
    input  wire logic              sendReady,
    // refusal report
    output logic                   rejectPulse,
    output logic [1:0]             rejectCause
);
    logic [CODE_W-1:0] convCode;
    logic              convOk;
    logic              railOk;
    logic              memFixOk;
    logic              accept;
    logic              refuse;
    reject_e           cause;

    logic              sendValid_r, sendValid_nxt;
    logic [ADDR_W-1:0] sendAddr_r, sendAddr_nxt;
    logic [CODE_W-1:0] sendCode_r, sendCode_nxt;
    logic              rejectPulse_r, rejectPulse_nxt;
    logic [1:0]        rejectCause_r, rejectCause_nxt;

    mv_to_code u_conv (
        .milliVolts       (reqMilliVolts),
        .voltageIdentCode (convCode),
        .inRange          (convOk)
    );

    // one packet held at a time; a new request waits until it leaves
    assign reqReady = !sendValid_r || sendReady;

    always_comb begin
        railOk   = (reqRail == ADDR_CORE) || (reqRail == ADDR_SYSAG) || (reqRail == ADDR_MEMSUP);
        // memory rail may be off or at its single strapped level
        memFixOk = (reqMilliVolts == '0) ||
                   (reqMilliVolts == (memHighSel ? MV_MEM_HIGH : MV_MEM_LOW));
        if (!railOk) begin
            cause = REJ_ADDR;
        end else if (!convOk) begin
            cause = REJ_RANGE;
        end else if ((reqRail == ADDR_MEMSUP) && !memFixOk) begin
            cause = REJ_MEMFIX;
        end else begin
            cause = REJ_NONE;
        end
        accept = reqValid && reqReady && (cause == REJ_NONE);
        refuse = reqValid && reqReady && (cause != REJ_NONE);
    end

    always_comb begin
        sendValid_nxt   = sendValid_r;
        sendAddr_nxt    = sendAddr_r;
        sendCode_nxt    = sendCode_r;
        rejectPulse_nxt = refuse;
        rejectCause_nxt = refuse ? cause : rejectCause_r;
        if (sendValid_r && sendReady) begin
            sendValid_nxt = 1'b0;
        end
        if (accept) begin
            sendValid_nxt = 1'b1;
            sendAddr_nxt  = reqRail;
            sendCode_nxt  = convCode;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sendValid_r   <= 1'b0;
            sendAddr_r    <= ADDR_CORE;
            sendCode_r    <= CODE_OFF;
            rejectPulse_r <= 1'b0;
            rejectCause_r <= REJ_NONE;
        end else begin
            sendValid_r   <= sendValid_nxt;
            sendAddr_r    <= sendAddr_nxt;
            sendCode_r    <= sendCode_nxt;
            rejectPulse_r <= rejectPulse_nxt;
            rejectCause_r <= rejectCause_nxt;
        end
    end

    assign sendValid   = sendValid_r;
    assign sendAddr    = sendAddr_r;
    assign sendCode    = sendCode_r;
    assign rejectPulse = rejectPulse_r;
    assign rejectCause = rejectCause_r;

    // packets never name an unassigned rail
    a_addr_assigned: assert property (@(posedge clock) disable iff (!rst_b)
        sendValid |-> (sendAddr <= ADDR_MEMSUP))
        else $error("packet carries unassigned rail address");

    // code is off or inside the linear range, never 01..32
    a_code_range: assert property (@(posedge clock) disable iff (!rst_b)
        sendValid |-> (sendCode == CODE_OFF || sendCode >= CODE_MIN))
        else $error("packet carries unused code");

    // accepted request shows up next cycle with the linear code
    a_code_linear: assert property (@(posedge clock) disable iff (!rst_b)
        (accept && reqMilliVolts != '0) |=>
            (sendValid && (11'(sendCode - CODE_MIN) * MV_STEP + MV_MIN == $past(reqMilliVolts))))
        else $error("code does not match requested voltage");

    // memory rail only carries off or the strapped fixed code
    a_mem_fixed: assert property (@(posedge clock) disable iff (!rst_b)
        (accept && reqRail == ADDR_MEMSUP) |=>
            (sendCode == CODE_OFF || sendCode == ($past(memHighSel) ? CODE_MEM_HIGH : CODE_MEM_LOW)))
        else $error("memory rail code not fixed");

    // address forwarded unchanged
    a_addr_forward: assert property (@(posedge clock) disable iff (!rst_b)
        accept |=> (sendAddr == $past(reqRail)))
        else $error("rail address not forwarded");

    // bad address flagged one cycle later with cause
    a_reject_flag: assert property (@(posedge clock) disable iff (!rst_b)
        (reqValid && reqReady && reqRail > ADDR_MEMSUP) |=>
            (rejectPulse && rejectCause == REJ_ADDR && !($rose(sendValid))))
        else $error("bad rail request not flagged");

    // held packet stays stable while stalled
    a_hold_stall: assert property (@(posedge clock) disable iff (!rst_b)
        (sendValid && !sendReady) |=> (sendValid && $stable(sendAddr) && $stable(sendCode)))
        else $error("packet changed while stalled");

    // reject pulse lasts one cycle unless another refusal follows
    a_pulse_once: assert property (@(posedge clock) disable iff (!rst_b)
        (rejectPulse && !refuse) |=> !rejectPulse)
        else $error("reject pulse stretched");

    // off-grid or out-of-range voltage on a good rail is refused as range
    a_range_reject: assert property (@(posedge clock) disable iff (!rst_b)
        (reqValid && reqReady && railOk && !convOk) |=>
            (rejectPulse && rejectCause == REJ_RANGE))
        else $error("range refusal not flagged");

    // memory rail away from its strapped level is refused as not fixed
    a_memfix_reject: assert property (@(posedge clock) disable iff (!rst_b)
        (reqValid && reqReady && reqRail == ADDR_MEMSUP && convOk && !memFixOk) |=>
            (rejectPulse && rejectCause == REJ_MEMFIX))
        else $error("memory level refusal not flagged");

    // a refused request never produces a packet
    a_refuse_silent: assert property (@(posedge clock) disable iff (!rst_b)
        refuse |=> !sendValid)
        else $error("refused request produced a packet");

    // cause is sticky between refusals so software can read it late
    a_cause_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !refuse |=> $stable(rejectCause))
        else $error("reject cause changed without refusal");

    // off request goes out as the off code
    a_off_code: assert property (@(posedge clock) disable iff (!rst_b)
        (accept && reqMilliVolts == '0) |=> (sendValid && sendCode == CODE_OFF))
        else $error("off request not sent as off code");

    // packet leaves after one taking edge when nothing replaces it
    a_send_release: assert property (@(posedge clock) disable iff (!rst_b)
        (sendValid && sendReady && !accept) |=> !sendValid)
        else $error("packet not released");

    // idle encoder always takes a request
    a_ready_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !sendValid |-> reqReady)
        else $error("idle encoder not ready");
endmodule

// ---- tb/regulator_model.sv ----
// regulator controller model taking packets off the encoder
// assumes the encoder clock; stall holds packets back
`timescale 1ns/1ps
module regulator_model
    import rail_vid_pkg::*;
#(
    parameter logic [CODE_W-1:0] MAX_CODE = 8'hFE
)
(
    // clock and flow control
    input  wire logic              clock,
    input  wire logic              stall,
    // packet from the encoder
    input  wire logic              sendValid,
    input  wire logic [ADDR_W-1:0] sendAddr,
    input  wire logic [CODE_W-1:0] sendCode,
    output logic                   sendReady,
    // last packet taken
    output logic [ADDR_W-1:0]      gotAddr,
    output logic [CODE_W-1:0]      gotCode,
    output logic                   notSup
);
    assign sendReady = !stall;
    always @(posedge clock) begin
        if (sendValid && sendReady) begin
            gotAddr <= sendAddr;
            gotCode <= sendCode;
            notSup  <= sendCode > MAX_CODE; // above programmed maximum
        end
    end
endmodule

// ---- tb/tb_regulator_rail_vid_encoder.sv ----
// self-checking bench for the rail address and voltage code encoder
// assumes regulator_model on the packet side
`timescale 1ns/1ps
module tb_regulator_rail_vid_encoder
    import rail_vid_pkg::*;
;
    logic              clock = 1'b0;
    logic              rst_b = 1'b0;
    logic              reqValid = 1'b0;
    logic              memHighSel = 1'b0;
    logic              stall = 1'b0;
    logic [ADDR_W-1:0] reqRail = 4'h0;
    logic [MV_W-1:0]   reqMilliVolts = 11'h000;
    logic              reqReady, sendValid, sendReady, rejectPulse, notSup;
    logic [ADDR_W-1:0] sendAddr, gotAddr;
    logic [CODE_W-1:0] sendCode, gotCode;
    logic [1:0]        rejectCause;
    int                fail_count = 0;
    int                cmp_count = 0;
    regulator_rail_vid_encoder DUT (.clock, .rst_b, .reqValid, .reqRail, .reqMilliVolts, .reqReady, .memHighSel,
        .sendValid, .sendAddr, .sendCode, .sendReady, .rejectPulse, .rejectCause);
    regulator_model peer (.clock, .stall, .sendValid, .sendAddr, .sendCode, .sendReady, .gotAddr, .gotCode, .notSup);
    always #10 clock = ~clock;
    function automatic logic [15:0] code_of(input logic [MV_W-1:0] mv);
        return (mv == 11'h000) ? 16'h0000 : 16'((mv - MV_MIN) / MV_STEP) + 16'h0033;
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // waits out a busy encoder, then one taking edge
    task automatic req(input logic [ADDR_W-1:0] r, input logic [MV_W-1:0] mv);
        int n;
        n = 0;
        @(posedge clock);
        reqValid <= 1'b1;
        reqRail <= r;
        reqMilliVolts <= mv;
        #1;
        while (reqReady !== 1'b1 && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        reqValid <= 1'b0;
        #1;
    endtask
    task automatic t_codes();
        logic [ADDR_W-1:0] r[5] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h1};
        logic [MV_W-1:0]   v[5] = '{11'h000, 11'h1F4, 11'h3AC, 11'h5F0, 11'h1F9};
        for (int i = 0; i < 5; i++) begin
            req(r[i], v[i]);
            chk("sendValid", 16'h0001, sendValid);
            chk("sendAddr", r[i], sendAddr);
            chk("sendCode", code_of(v[i]), sendCode);
        end
    endtask
    task automatic t_mem();
        req(ADDR_MEMSUP, MV_MEM_LOW);
        chk("memLow", 16'h00DD, sendCode);
        @(posedge clock);
        memHighSel <= 1'b1;
        req(ADDR_MEMSUP, MV_MEM_HIGH);
        chk("memHigh", 16'h00FB, sendCode);
    endtask
    task automatic t_refuse();
        logic [ADDR_W-1:0] r[8] = '{4'h3, 4'h4, 4'h5, 4'hF, 4'h0, 4'h1, 4'h0, ADDR_MEMSUP};
        logic [MV_W-1:0]   v[8] = '{11'h3E8, 11'h3E8, 11'h3E8, 11'h3E8, 11'h1EF, 11'h5F1, 11'h1F6, 11'h578};
        logic [1:0]        c[8] = '{REJ_ADDR, REJ_ADDR, REJ_ADDR, REJ_ADDR, REJ_RANGE, REJ_RANGE, REJ_RANGE, REJ_MEMFIX};
        for (int i = 0; i < 8; i++) begin
            req(r[i], v[i]);
            chk("rejectPulse", 16'h0001, rejectPulse);
            chk("rejectCause", c[i], rejectCause);
            chk("sendValid", 16'h0000, sendValid);
            @(posedge clock);
            #1;
            chk("rejectPulse", 16'h0000, rejectPulse);
        end
    endtask
    // packet must stand while the regulator stalls
    task automatic t_stall();
        @(posedge clock);
        stall <= 1'b1;
        req(ADDR_SYSAG, 11'h3E8);
        repeat (3) @(posedge clock);
        #1;
        chk("sendValid", 16'h0001, sendValid);
        chk("reqReady", 16'h0000, reqReady);
        @(posedge clock);
        stall <= 1'b0;
        @(posedge clock);
        #1;
        chk("gotAddr", ADDR_SYSAG, gotAddr);
        chk("gotCode", 16'h0097, gotCode);
        chk("notSup", 16'h0000, notSup);
        // top code lies above the regulator's programmed maximum
        req(ADDR_CORE, MV_MAX);
        @(posedge clock);
        #1;
        chk("notSupTop", 16'h0001, notSup);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk("resetValid", 16'h0000, sendValid);
        t_codes();
        t_mem();
        t_refuse();
        t_stall();
        wrap_up();
    end
    // generous against some 60 cycles of tests
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
endmodule
